// ===== shared/dgc_pkg.sv
/*
 * Shared constants and types of the DMA global control block: register
 * offsets, field positions, reset values, table geometry and descriptor modes.
 * Assumes a 32-bit AXI4-Lite register bus and a 32-bit memory master port.
 */
`default_nettype none

package dgc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] DGC_OFF_STATUS = 8'h00;
    localparam logic [7:0] DGC_OFF_CFG = 8'h04;
    localparam logic [7:0] DGC_OFF_CTL_BASE = 8'h08;
    localparam logic [7:0] DGC_OFF_ALT_BASE = 8'h0c;
    localparam logic [7:0] DGC_OFF_SW_REQ = 8'h14;
    localparam logic [7:0] DGC_OFF_ENA_SET = 8'h28;
    localparam logic [7:0] DGC_OFF_ENA_CLR = 8'h2c;
    localparam logic [7:0] DGC_OFF_ATTR = 8'h30;
    localparam logic [7:0] DGC_OFF_ERR_CLR = 8'h4c;
    localparam logic [7:0] DGC_OFF_CH_IRQ = 8'h50;

    // ------------------------------------------------------------------
    // Fields, reset values and geometry
    // ------------------------------------------------------------------
    localparam int DGC_CFG_MASTER_EN_BIT = 0;
    localparam int DGC_TABLE_ALIGN_BITS = 10;
    localparam logic [31:0] DGC_TABLE_HALF = 32'h0000_0200;
    localparam logic [31:0] DGC_RST_ZERO = 32'h0000_0000;
    localparam int DGC_NUM_CH = 32;
    localparam logic [4:0] DGC_SW_CHANNEL = 5'h1e;
    localparam logic [3:0] DGC_DESC_BYTES = 4'h0;
    localparam logic [3:0] DGC_CTRL_WORD_OFS = 4'h8;
    localparam int DGC_MODE_LSB = 0;
    localparam int DGC_CNT_LSB = 4;
    localparam int DGC_ARB_LSB = 14;
    localparam logic [2:0] DGC_MODE_STOP = 3'h0;
    localparam logic [2:0] DGC_MODE_AUTO = 3'h2;
    localparam logic [10:0] DGC_ARB_EIGHT = 11'h008;

    typedef enum logic [1:0] {
        DGC_RESP_OKAY = 2'h0,
        DGC_RESP_SLVERR = 2'h2
    } dgc_resp_t;

endpackage : dgc_pkg

`default_nettype wire

// ===== rtl/dgc_mem_port.sv
/*
 * Single-word memory master used by the transfer engine: one read or write
 * at a time, level request held until taken, one-cycle done with an error flag.
 * Assumes the memory answers every access with ack, possibly with err.
 */
`timescale 1ns/1ps
`default_nettype none

module dgc_mem_port
    import dgc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic req,
    input wire logic req_we,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic done,
    output logic done_err,
    output logic [31:0] done_rdata,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] mem_rdata
);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= DGC_RST_ZERO;
            mem_wdata <= DGC_RST_ZERO;
            done <= 1'b0;
            done_err <= 1'b0;
            done_rdata <= DGC_RST_ZERO;
        end else if (ce) begin
            done <= 1'b0;
            if (mem_req && mem_ack) begin
                mem_req <= 1'b0;
                done <= 1'b1;
                done_err <= mem_err;
                done_rdata <= mem_rdata;
            // No new access in the done cycle: the requester still shows its old
            // state then, and a request taken there would repeat the last access.
            end else if (!mem_req && !done && req) begin
                mem_req <= 1'b1;
                mem_we <= req_we;
                mem_addr <= req_addr;
                mem_wdata <= req_wdata;
            end
        end
    end

endmodule : dgc_mem_port

`default_nettype wire

// ===== rtl/dgc_irq_flags.sv
/*
 * Sticky channel completion flags and the error-pending flag.
 * Assumes set pulses and clear strobes come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dgc_irq_flags
    import dgc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [31:0] ch_set,
    input wire logic [31:0] ch_clr_mask,
    input wire logic ch_clr,
    input wire logic err_set,
    input wire logic err_clr,
    output logic [31:0] ch_status,
    output logic err_pending
);

    // A set in the same cycle as its clear wins, so no completion is lost.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch_status <= DGC_RST_ZERO;
        end else if (ce) begin
            ch_status <= (ch_status & ~(ch_clr ? ch_clr_mask : DGC_RST_ZERO)) | ch_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_pending <= 1'b0;
        end else if (ce) begin
            if (err_set) begin
                err_pending <= 1'b1;
            end else if (err_clr) begin
                err_pending <= 1'b0;
            end
        end
    end

endmodule : dgc_irq_flags

`default_nettype wire

// ===== rtl/dgc_top.sv
/*
 * DMA global control: AXI4-Lite registers, control table base, master enable,
 * error and channel interrupt status, and the software-channel auto transfer.
 * Assumes a word-wide memory answering each access with ack, and software
 * programming the table and descriptor before issuing a request.
 */
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module dgc_top
    import dgc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] mem_rdata,
    output logic sw_channel_interrupt,
    output logic error_interrupt_line,
    output logic [31:0] periph_done
);

    typedef enum logic [2:0] {
        DGC_IDLE, DGC_FETCH_CTRL, DGC_FETCH_SRC, DGC_FETCH_DST,
        DGC_RD_ITEM, DGC_WR_ITEM, DGC_WRITEBACK
    } dgc_state_t;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [31:0] dgc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : dgc_merge

    function automatic logic dgc_mapped(input logic [7:0] a);
        return a == DGC_OFF_STATUS || a == DGC_OFF_CFG || a == DGC_OFF_CTL_BASE
            || a == DGC_OFF_ALT_BASE || a == DGC_OFF_SW_REQ || a == DGC_OFF_ENA_SET
            || a == DGC_OFF_ENA_CLR || a == DGC_OFF_ATTR || a == DGC_OFF_ERR_CLR
            || a == DGC_OFF_CH_IRQ;
    endfunction : dgc_mapped

    // ------------------------------------------------------------------
    // Registers and signals
    // ------------------------------------------------------------------
    logic master_en_q;
    logic [31:0] ctl_base_q;
    logic [31:0] ch_enable_q;
    logic [31:0] attr_q;
    logic [7:0] aw_addr_q;
    logic aw_full_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_full_q;
    logic wr_fire;
    logic wr_ok;
    logic [31:0] wr_val;
    logic [31:0] rd_val;
    logic [31:0] ch_status;
    logic err_pending;
    logic [31:0] ch_set;
    logic err_set;
    logic [4:0] pend_ch;
    logic pend_valid;
    dgc_state_t state_q;
    logic [4:0] cur_ch_q;
    logic [31:0] ctrl_q;
    logic [31:0] src_q;
    logic [31:0] dst_q;
    logic [9:0] left_q;
    logic [7:0] item_q;
    logic [3:0] arb_q;
    logic busy_q;
    logic mp_req;
    logic mp_we;
    logic [31:0] mp_addr;
    logic [31:0] mp_wdata;
    logic mp_done;
    logic mp_err;
    logic [31:0] mp_rdata;
    logic [31:0] desc_addr;
    logic [31:0] ctrl_done;

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    assign s_axi_awready = ce && !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_full_q && !s_axi_bvalid;
    assign wr_fire = ce && aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_ok = wr_fire && dgc_mapped(aw_addr_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_full_q <= 1'b0;
            w_data_q <= DGC_RST_ZERO;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DGC_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? DGC_RESP_OKAY : DGC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign wr_val = dgc_merge(DGC_RST_ZERO, w_data_q, w_strb_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_en_q <= 1'b0;
            ctl_base_q <= DGC_RST_ZERO;
            attr_q <= DGC_RST_ZERO;
        end else if (ce && wr_ok) begin
            if (aw_addr_q == DGC_OFF_CFG && w_strb_q[0]) begin
                master_en_q <= w_data_q[DGC_CFG_MASTER_EN_BIT];
            end
            if (aw_addr_q == DGC_OFF_CTL_BASE) begin
                ctl_base_q <= dgc_merge(ctl_base_q, w_data_q, w_strb_q)
                    & ~((32'h1 << DGC_TABLE_ALIGN_BITS) - 32'h1);
            end
            if (aw_addr_q == DGC_OFF_ATTR) begin
                attr_q <= dgc_merge(attr_q, w_data_q, w_strb_q);
            end
        end
    end

    // Enables are set by software and cleared by completion; set beats clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch_enable_q <= DGC_RST_ZERO;
        end else if (ce) begin
            ch_enable_q <= (ch_enable_q & ~ctrl_done
                & ~((wr_ok && aw_addr_q == DGC_OFF_ENA_CLR) ? wr_val : DGC_RST_ZERO))
                | ((wr_ok && aw_addr_q == DGC_OFF_ENA_SET) ? wr_val : DGC_RST_ZERO);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    assign s_axi_arready = ce && !s_axi_rvalid;

    always_comb begin
        rd_val = DGC_RST_ZERO;
        unique case (s_axi_araddr & 8'hfc)
            DGC_OFF_STATUS: rd_val = {30'h0, busy_q, master_en_q};
            DGC_OFF_CFG: rd_val = {31'h0, master_en_q};
            DGC_OFF_CTL_BASE: rd_val = ctl_base_q;
            DGC_OFF_ALT_BASE: rd_val = ctl_base_q + DGC_TABLE_HALF;
            DGC_OFF_ENA_SET: rd_val = ch_enable_q;
            DGC_OFF_ATTR: rd_val = attr_q;
            DGC_OFF_ERR_CLR: rd_val = {31'h0, err_pending};
            DGC_OFF_CH_IRQ: rd_val = ch_status;
            default: rd_val = DGC_RST_ZERO;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= DGC_RST_ZERO;
            s_axi_rresp <= DGC_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= dgc_mapped(s_axi_araddr & 8'hfc) ? DGC_RESP_OKAY
                    : DGC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------------
    // Requests are single-shot writes; one pending request is held so that a
    // request made while another transfer runs is not dropped.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_valid <= 1'b0;
            pend_ch <= 5'h00;
        end else if (ce) begin
            if (wr_ok && aw_addr_q == DGC_OFF_SW_REQ
                    && ch_enable_q[w_data_q[4:0]] && !pend_valid) begin
                pend_valid <= 1'b1;
                pend_ch <= w_data_q[4:0];
            end else if (state_q == DGC_IDLE && master_en_q) begin
                pend_valid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------------
    assign desc_addr = ctl_base_q | {23'h0, cur_ch_q, DGC_DESC_BYTES};

    always_comb begin
        mp_req = 1'b0;
        mp_we = 1'b0;
        mp_addr = desc_addr;
        mp_wdata = DGC_RST_ZERO;
        unique case (state_q)
            DGC_IDLE: mp_req = 1'b0;
            DGC_FETCH_CTRL: begin
                mp_req = 1'b1;
                mp_addr = desc_addr + {28'h0, DGC_CTRL_WORD_OFS};
            end
            DGC_FETCH_SRC: mp_req = 1'b1;
            DGC_FETCH_DST: begin
                mp_req = 1'b1;
                mp_addr = desc_addr + 32'h4;
            end
            DGC_RD_ITEM: begin
                mp_req = master_en_q;
                mp_addr = src_q;
            end
            DGC_WR_ITEM: begin
                mp_req = master_en_q;
                mp_we = 1'b1;
                mp_addr = dst_q;
                mp_wdata = {24'h0, item_q};
            end
            DGC_WRITEBACK: begin
                mp_req = 1'b1;
                mp_we = 1'b1;
                mp_addr = desc_addr + {28'h0, DGC_CTRL_WORD_OFS};
                mp_wdata = {ctrl_q[31:14], 10'h000, 1'b0, DGC_MODE_STOP};
            end
        endcase
    end

    // Once a transfer has started it needs no further request: auto mode.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= DGC_IDLE;
            cur_ch_q <= 5'h00;
            ctrl_q <= DGC_RST_ZERO;
            src_q <= DGC_RST_ZERO;
            dst_q <= DGC_RST_ZERO;
            left_q <= 10'h000;
            item_q <= 8'h00;
            arb_q <= 4'h0;
            busy_q <= 1'b0;
        end else if (ce) begin
            unique case (state_q)
                DGC_IDLE: if (pend_valid && master_en_q) begin
                    state_q <= DGC_FETCH_CTRL;
                    cur_ch_q <= pend_ch;
                    busy_q <= 1'b1;
                end
                DGC_FETCH_CTRL: if (mp_done) begin
                    ctrl_q <= mp_rdata;
                    left_q <= mp_rdata[DGC_CNT_LSB +: 10] + 10'h001;
                    state_q <= mp_err ? DGC_IDLE : DGC_FETCH_SRC;
                    busy_q <= !mp_err;
                end
                DGC_FETCH_SRC: if (mp_done) begin
                    src_q <= mp_rdata;
                    state_q <= mp_err ? DGC_IDLE : DGC_FETCH_DST;
                    busy_q <= !mp_err;
                end
                DGC_FETCH_DST: if (mp_done) begin
                    dst_q <= mp_rdata;
                    arb_q <= 4'h0;
                    state_q <= mp_err ? DGC_IDLE : DGC_RD_ITEM;
                    busy_q <= !mp_err;
                end
                DGC_RD_ITEM: if (mp_done) begin
                    item_q <= mp_rdata[7:0];
                    state_q <= mp_err ? DGC_IDLE : DGC_WR_ITEM;
                    busy_q <= !mp_err;
                end
                DGC_WR_ITEM: if (mp_done) begin
                    src_q <= src_q + 32'h1;
                    dst_q <= dst_q + 32'h1;
                    left_q <= left_q - 10'h001;
                    arb_q <= (arb_q == DGC_ARB_EIGHT[3:0] - 4'h1) ? 4'h0 : arb_q + 4'h1;
                    if (mp_err) begin
                        state_q <= DGC_IDLE;
                        busy_q <= 1'b0;
                    end else if (left_q == 10'h001) begin
                        state_q <= DGC_WRITEBACK;
                    end else begin
                        state_q <= DGC_RD_ITEM;
                    end
                end
                DGC_WRITEBACK: if (mp_done) begin
                    state_q <= DGC_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    assign err_set = mp_done && mp_err;
    assign ctrl_done = (state_q == DGC_WRITEBACK && mp_done && !mp_err)
        ? (32'h1 << cur_ch_q) : DGC_RST_ZERO;
    assign ch_set = ctrl_done & (32'h1 << DGC_SW_CHANNEL);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_done <= DGC_RST_ZERO;
        end else if (ce) begin
            periph_done <= ctrl_done & ~(32'h1 << DGC_SW_CHANNEL);
        end
    end

    assign sw_channel_interrupt = ch_status[DGC_SW_CHANNEL];
    assign error_interrupt_line = err_pending;

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    dgc_mem_port u_mem (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .req(mp_req),
        .req_we(mp_we),
        .req_addr(mp_addr),
        .req_wdata(mp_wdata),
        .done(mp_done),
        .done_err(mp_err),
        .done_rdata(mp_rdata),
        .mem_req(mem_req),
        .mem_we(mem_we),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .mem_ack(mem_ack),
        .mem_err(mem_err),
        .mem_rdata(mem_rdata)
    );

    dgc_irq_flags u_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .ch_set(ch_set),
        .ch_clr_mask(wr_val),
        .ch_clr(wr_ok && aw_addr_q == DGC_OFF_CH_IRQ),
        .err_set(err_set),
        .err_clr(wr_ok && aw_addr_q == DGC_OFF_ERR_CLR && w_strb_q[0] && w_data_q[0]),
        .ch_status(ch_status),
        .err_pending(err_pending)
    );

endmodule : dgc_top

`default_nettype wire

// ===== verification/dgc_top_checker.sv
/* Port assertions for dgc_top.
   Assumes one clock and the synchronous low reset. */
`timescale 1ns/1ps
`default_nettype none
module dgc_top_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_wvalid,
    input wire logic mem_req,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] mem_addr,
    input wire logic sw_channel_interrupt,
    input wire logic error_interrupt_line,
    input wire logic [31:0] periph_done
);
    logic [2:0] since_q;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk) begin
        if (!aresetn)
            since_q <= 3'h7;
        else if (mem_req && mem_ack && mem_err)
            since_q <= 3'h0;
        else if (since_q != 3'h7)
            since_q <= since_q + 3'h1;
    end
    a_err_raise: assert property (
        mem_req && mem_ack && mem_err |-> ##[1:4] error_interrupt_line) else $error("no err");
    a_err_cause: assert property (
        $rose(error_interrupt_line) |-> since_q <= 3'h3) else $error("err no cause");
    a_err_hold: assert property (
        error_interrupt_line |=> error_interrupt_line || $past(s_axi_wvalid)
        || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3)) else $error("err lost");
    a_sw_hold: assert property (
        sw_channel_interrupt |=> sw_channel_interrupt || $past(s_axi_wvalid)
        || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3)) else $error("irq lost");
    a_no_sw_done: assert property (!periph_done[30]) else $error("sw done");
    a_done_pulse: assert property (
        |periph_done |=> periph_done == 32'h0) else $error("done long");
    a_mem_hold: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("req moved");
    a_mem_gap: assert property (
        mem_req && mem_ack |=> !mem_req) else $error("no gap");
endmodule : dgc_top_checker
bind dgc_top dgc_top_checker dgc_top_checker_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_wvalid(s_axi_wvalid), .mem_req(mem_req), .mem_ack(mem_ack), .mem_err(mem_err),
    .mem_addr(mem_addr), .sw_channel_interrupt(sw_channel_interrupt),
    .error_interrupt_line(error_interrupt_line), .periph_done(periph_done));
`default_nettype wire

// ===== verification/dgc_mem.sv
/* Word memory on the master port, answering after 0 to 3 cycles.
   Assumes each request is held until acknowledged. */
`timescale 1ns/1ps
`default_nettype none
module dgc_mem (
    input wire logic aclk,
    input wire logic req,
    input wire logic we,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] err_addr,
    input wire logic slow,
    output logic ack = 1'h0,
    output logic err = 1'h0,
    output logic [31:0] rdata = 32'h0
);
    logic [31:0] m [logic [31:0]];
    int dly = 0;
    // Released data shows the inverse, so a late sample never passes for data.
    always @(posedge aclk) begin
        if (ack) begin
            ack <= 1'h0;
            err <= 1'h0;
            rdata <= ~rdata;
        end else if (req && dly > 0) begin
            dly <= dly - 1;
        end else if (req) begin
            ack <= 1'h1;
            err <= (addr === err_addr);
            rdata <= m.exists(addr) ? m[addr] : ~rdata;
            if (we && addr !== err_addr)
                m[addr] = wdata;
            dly <= slow ? $urandom_range(3) : 0;
        end
    end
endmodule : dgc_mem
`default_nettype wire

// ===== verification/test_dgc_top.sv
/* Self-checking bench of dgc_top over AXI4-Lite with a memory model.
   Assumes the register map and descriptor layout of dgc_pkg. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_dgc_top;
    import dgc_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, slow = 1'h0, awv = 1'h0, wv = 1'h0, bq = 1'h0;
    logic arv = 1'h0, rq = 1'h0, awr, wr, bv, arr, rv, mq, mw, ma, me, swi, eri;
    logic [1:0] br, rr, rs;
    logic [7:0] aa = 8'h0, ra = 8'h0;
    logic [31:0] wd = 32'h0, ea = '1, seen = 32'h0, irq, rdat, mad, mwd, mrd, pd, got;
    logic [31:0] base, src, dst;
    int num_errors = 0, compares = 0, n;
    dgc_top dgc_top_inst (.aclk(clk), .aresetn(rst_n), .ce(1'h1), .s_axi_awaddr(aa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bq), .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rq),
        .mem_req(mq), .mem_we(mw), .mem_addr(mad), .mem_wdata(mwd), .mem_ack(ma),
        .mem_err(me), .mem_rdata(mrd), .sw_channel_interrupt(swi),
        .error_interrupt_line(eri), .periph_done(pd));
    dgc_mem dgc_mem_inst (.aclk(clk), .req(mq), .we(mw), .addr(mad), .wdata(mwd),
        .err_addr(ea), .slow(slow), .ack(ma), .err(me), .rdata(mrd));
    initial forever #5 clk = ~clk;
    always @(posedge clk) seen <= seen | pd;
    // Ready is sampled at the falling edge; it cannot change before the next rise.
    task automatic xfer(input bit r, input logic [7:0] a, input logic [31:0] d);
        bit ta, tw, tb;
        aa <= a;
        ra <= a;
        wd <= d;
        arv <= r;
        rq <= r;
        awv <= !r;
        wv <= !r;
        bq <= !r;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk);
            ta = r ? arr : awr;
            tw = wr && !r;
            tb = r ? rv : bv;
            got = rdat;
            rs = r ? rr : br;
            @(posedge clk);
            if (ta) arv <= 1'h0;
            if (ta) awv <= 1'h0;
            if (tw) wv <= 1'h0;
        end
    endtask : xfer
    task automatic rd_is(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b1, a, 32'h0);
        `CHK(got, e)
    endtask : rd_is
    task automatic prep(input logic [4:0] ch);
        src = $urandom & 32'h7fff_fff0;
        dst = src ^ 32'h8000_0000;
        for (int i = 0; i < n; i++) dgc_mem_inst.m[src + i] = $urandom;
        dgc_mem_inst.m[base + ch * 16] = src;
        dgc_mem_inst.m[base + ch * 16 + 4] = dst;
        dgc_mem_inst.m[base + ch * 16 + 8] = 32'(DGC_MODE_AUTO) | 32'(n - 1) << DGC_CNT_LSB
            | 32'(DGC_ARB_EIGHT) << DGC_ARB_LSB;
        xfer(1'b0, DGC_OFF_ENA_SET, 32'h1 << ch);
        xfer(1'b0, DGC_OFF_SW_REQ, 32'(ch));
    endtask : prep
    task automatic post(input logic [4:0] ch);
        rd_is(DGC_OFF_ENA_SET, 32'h0);
        for (int i = 0; i < n; i++) `CHK(dgc_mem_inst.m[dst + i][7:0], dgc_mem_inst.m[src + i][7:0])
        got = dgc_mem_inst.m[base + ch * 16 + 8];
        `CHK(got[2:0], DGC_MODE_STOP)
        `CHK(got[13:4], 10'h0)
    endtask : post
    initial begin
        void'($urandom(73));
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        rd_is(DGC_OFF_ATTR, 32'h0);
        rd_is(DGC_OFF_CH_IRQ, 32'h0);
        base = $urandom;
        xfer(1'b0, DGC_OFF_CTL_BASE, base);
        base[9:0] = 10'h0;
        rd_is(DGC_OFF_CTL_BASE, base);
        rd_is(DGC_OFF_ALT_BASE, base + DGC_TABLE_HALF);
        $display("test base done");
        n = 1 + $urandom_range(15);
        prep(DGC_SW_CHANNEL);
        repeat (40) @(negedge clk);
        `CHK({swi, mq}, 2'h0)
        @(posedge clk);
        slow <= 1'h1;
        xfer(1'b0, DGC_OFF_CFG, 32'h1);
        while (swi !== 1'h1) @(negedge clk);
        @(posedge clk);
        post(DGC_SW_CHANNEL);
        irq = 32'h1 << DGC_SW_CHANNEL;
        rd_is(DGC_OFF_CH_IRQ, irq);
        xfer(1'b0, 8'h44, '1);
        `CHK(rs, DGC_RESP_SLVERR)
        xfer(1'b0, DGC_OFF_CH_IRQ, ~irq);
        rd_is(DGC_OFF_CH_IRQ, irq);
        xfer(1'b0, DGC_OFF_CH_IRQ, irq);
        rd_is(DGC_OFF_CH_IRQ, 32'h0);
        `CHK(swi, 1'h0)
        $display("test software channel done");
        prep(5'h5);
        while (seen[5] !== 1'h1) @(negedge clk);
        @(posedge clk);
        post(5'h5);
        `CHK({swi, seen}, {1'h0, 32'h20})
        $display("test peripheral channel done");
        ea <= base + 32'(DGC_SW_CHANNEL) * 16 + 4;
        prep(DGC_SW_CHANNEL);
        while (eri !== 1'h1) @(negedge clk);
        @(posedge clk);
        rd_is(DGC_OFF_ERR_CLR, 32'h1);
        rd_is(DGC_OFF_CH_IRQ, 32'h0);
        xfer(1'b0, DGC_OFF_ERR_CLR, 32'h1);
        rd_is(DGC_OFF_ERR_CLR, 32'h0);
        `CHK(eri, 1'h0)
        $display("test error done");
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test;
    end
    task automatic stop_test;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
endmodule : test_dgc_top
`default_nettype wire
